// file: rtl/pif_pkg.sv
package pif_pkg;
  // system clock and derived bit clocks
  localparam int CLK_KHZ = 125000;
  localparam int F_LO_KHZ = 2000;
  localparam int F_HI_KHZ = 2667;
  // bit, frame and repetition lengths in bit-clock cycles
  localparam int BIT_LO = 16;
  localparam int BIT_HI = 14;
  localparam int FRM_LO = 400;
  localparam int FRM_HI = 350;
  localparam int FRM16_HI = 294;
  localparam int CYC_LO = 600;
  localparam int CYC_HI = 533;
  localparam int SLOT1_LO = 88;
  localparam int SLOT1_HI = 119;
  localparam int SLOT2_LO = 540;
  localparam int SLOT2_HI = 570;
  localparam int LEN20 = 25;
  localparam int LEN16 = 21;
  // start-up timing
  localparam int PH1_MS = 100;
  localparam int SYNC_MIN_MS = 4;
  localparam int PH1_CYC = PH1_MS * CLK_KHZ;
  localparam int SYNC_MIN_CYC = SYNC_MIN_MS * CLK_KHZ;
  localparam int PH3_FRAMES = 8;
  // 10-bit status and init codes
  localparam logic [9:0] CODE_READY = 10'h1E7;
  localparam logic [9:0] CODE_DEFECT = 10'h1F4;
  localparam logic [9:0] CODE_OVV = 10'h1EA;
  localparam logic [9:0] CODE_UVV = 10'h1EC;
  localparam logic [9:0] CODE_MAG = 10'h1EB;
  localparam logic [9:0] ID_BASE = 10'h200;
  localparam logic [9:0] NIB_BASE = 10'h210;
  localparam logic [3:0] REV13 = 4'h4;
  localparam logic [3:0] REV21 = 4'h6;
  localparam logic [7:0] CNT22 = 8'h10;
  localparam logic [7:0] CNT32 = 8'h26;
  localparam logic [5:0] NIB22_LAST = 6'h15;
  localparam logic [5:0] NIB32_LAST = 6'h1F;
  localparam logic [2:0] CRC_SEED = 3'h7;
  localparam int FIFO_DEPTH = 8;
  localparam int SMP_W = 16;

  typedef enum logic [1:0] {PH_INIT1, PH_INIT2, PH_INIT3, PH_RUN} pif_phase_t;

  typedef struct packed {
    logic mode16;
    logic high_rate;
    logic sync_mode;
    logic dual_slot;
    logic rev21;
    logic blocks32;
    logic [1:0] rep_k;
    logic [7:0] vendor;
    logic [7:0] stype;
    logic [19:0] sparam;
    logic [15:0] pdate;
    logic [23:0] lot_serial;
  } pif_cfg_t;

  typedef struct packed {
    logic defect;
    logic ovv;
    logic uvv;
    logic mag;
  } pif_diag_t;
endpackage

// file: rtl/pif_framer.sv
// Overview of operation
// - low-rate async bit lasts 16 ticks of the 2 MHz clock.
// - low-rate 20-bit frame lasts 400 ticks of the 2 MHz clock.
// - low-rate async frames start every 600 ticks, about 300 us.
// - high-rate async bit lasts 14 ticks of the 2.67 MHz clock.
// - high-rate 20-bit frame lasts 350 ticks of the 2.67 MHz clock, 16-bit 294.
// - high-rate async frames repeat every 533 ticks, about 200 us.
// - after reset, three init phases run before any run-mode output.
// - phase one sends nothing for typically 100 ms.
// - in sync mode a sync pulse after 4 ms ends phase one early.
// - dual-slot operation sends the same init frame in both slots.
// - 20-bit init puts the value in A15..A6; low bits, F and E0 zero.
// - 20-bit order: two zero starts, F0-F2, E0, A0-A15, C2 C1 C0.
// - 16-bit init: starts, E0, A0-A14, CRC; value in A14..A5.
// - phase three sends 0x1E7 when healthy, 0x1F4 once a defect is flagged.
// - once defect is reported, defect frames continue until power removal.
// - supply and gain conditions are held back until run mode.
// - 16-bit ready fills low bits with ones, defect with zeros.
// - phase two alternates ID and nibble frames, repeated k times (1..4).
// - IDs encode as 0x200 plus the low four bits of n, nibbles as 0x210 plus nibble.
// - first nibble is protocol revision, next two the block count.
// - the next nineteen come from stored vendor, type, parameter, date and serial data; any later ones read zero.
// - run mode is continuous when async, sync-pulse triggered when sync.
// - a sync pulse during a frame aborts it and restarts the slots.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pif_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ff;
  logic [AW:0] rd_ff;
  logic push;
  logic pop;

  assign out_valid_o = wr_ff != rd_ff;
  assign in_ready_o = wr_ff != {~rd_ff[AW], rd_ff[AW-1:0]};
  assign out_data_o = mem[rd_ff[AW-1:0]];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ff[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module pif_framer #(
  parameter int PH1_CYC = pif_pkg::PH1_CYC,
  parameter int SYNC_MIN_CYC = pif_pkg::SYNC_MIN_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // configuration and diagnostics
  input wire pif_pkg::pif_cfg_t cfg_i,
  input wire pif_pkg::pif_diag_t diag_i,
  // receiver sync pulse pin
  input wire logic sync_i,
  // run-mode samples
  input wire logic smp_valid_i,
  output logic smp_ready_o,
  input wire logic [pif_pkg::SMP_W-1:0] smp_data_i,
  // line output and status
  output logic psi5_tx_o,
  output logic tx_active_o,
  output logic [1:0] phase_o
);
  // frame vector, transmit order from bit 24 down; check bits augmented by three zeros
  function automatic logic [24:0] pif_build(logic m16, logic [2:0] f, logic e0, logic [15:0] a);
    logic [21:0] p;
    logic [2:0] c;
    logic fb;
    logic [24:0] v;
    int n;
    p = '0;
    v = '0;
    if (m16) begin
      n = 16;
      p[0] = e0;
      for (int i = 0; i < 15; i++) begin
        p[i+1] = a[i];
      end
    end else begin
      n = 20;
      p[2:0] = f;
      p[3] = e0;
      for (int i = 0; i < 16; i++) begin
        p[i+4] = a[i];
      end
    end
    c = pif_pkg::CRC_SEED;
    // plain division form: data enters at the low end, three zeros flush it through
    for (int i = 0; i < 23; i++) begin
      if (i < n + 3) begin
        fb = c[2];
        c = {c[1], c[0] ^ fb, ((i < n) ? p[i] : 1'b0) ^ fb};
      end
    end
    for (int i = 0; i < 20; i++) begin
      if (i < n) begin
        v[22-i] = p[i];
      end
    end
    v[22-n] = c[2];
    v[21-n] = c[1];
    v[20-n] = c[0];
    return v;
  endfunction

  function automatic logic [15:0] pif_place(logic m16, logic [9:0] val, logic low_ones);
    if (m16) begin
      return {1'b0, val, {5{low_ones}}};
    end
    return {val, 6'h00};
  endfunction

  pif_pkg::pif_cfg_t cfg_ff;
  logic cfg_ok_ff;
  logic [16:0] acc_ff;
  logic [16:0] acc_sum;
  logic [16:0] acc_inc;
  logic tick;
  logic sync_s1_ff;
  logic sync_s2_ff;
  logic sync_s3_ff;
  logic sync_rise;
  pif_pkg::pif_phase_t phase_ff;
  logic [23:0] ph1_cnt_ff;
  logic defect_ff;
  logic [9:0] sched_ff;
  logic sched_run_ff;
  logic [4:0] bit_len;
  logic [9:0] cyc_len;
  logic [9:0] slot1;
  logic [9:0] slot2;
  logic req_first;
  logic req_any;
  logic abort;
  logic start_tx;
  logic [24:0] frm_ff;
  logic [24:0] new_frame;
  logic [24:0] tx_frame;
  logic tx_busy_ff;
  logic [4:0] bit_left_ff;
  logic [4:0] btick_ff;
  logic [24:0] sh_ff;
  logic [9:0] frm_ticks_ff;
  logic [5:0] nib_ff;
  logic is_data_ff;
  logic [1:0] rep_ff;
  logic [3:0] ph3_cnt_ff;
  logic [2:0] fcnt_ff;
  logic [15:0] last_smp_ff;
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic fifo_pop;
  logic [87:0] nib_vec;
  logic [3:0] nibble;
  logic [5:0] nib_last;
  logic [9:0] val;
  logic [15:0] a_word;
  logic e0;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration caught once after reset release
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_ff <= '0;
      cfg_ok_ff <= 1'b0;
    end else if (!cfg_ok_ff) begin
      cfg_ff <= cfg_i;
      cfg_ok_ff <= 1'b1;
    end
  end

  // fractional divider: one tick per bit-clock period, jitter below one mclk
  always_comb begin
    acc_inc = cfg_ff.high_rate ? 17'(pif_pkg::F_HI_KHZ) : 17'(pif_pkg::F_LO_KHZ);
    acc_sum = acc_ff + acc_inc;
    tick = cfg_ok_ff & (acc_sum >= 17'(pif_pkg::CLK_KHZ));
    bit_len = cfg_ff.high_rate ? 5'(pif_pkg::BIT_HI) : 5'(pif_pkg::BIT_LO);
    cyc_len = cfg_ff.high_rate ? 10'(pif_pkg::CYC_HI) : 10'(pif_pkg::CYC_LO);
    slot1 = cfg_ff.high_rate ? 10'(pif_pkg::SLOT1_HI) : 10'(pif_pkg::SLOT1_LO);
    slot2 = cfg_ff.high_rate ? 10'(pif_pkg::SLOT2_HI) : 10'(pif_pkg::SLOT2_LO);
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_ff <= '0;
    end else if (cfg_ok_ff) begin
      acc_ff <= tick ? acc_sum - 17'(pif_pkg::CLK_KHZ) : acc_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sync pin synchroniser; the second and third stages feed the edge detector
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync_s1_ff <= 1'b0;
      sync_s2_ff <= 1'b0;
      sync_s3_ff <= 1'b0;
    end else begin
      sync_s1_ff <= sync_i;
      sync_s2_ff <= sync_s1_ff;
      sync_s3_ff <= sync_s2_ff;
    end
  end
  assign sync_rise = sync_s2_ff & ~sync_s3_ff & cfg_ff.sync_mode;

  ////////////////////////////////////////////////////////////////////////////////
  // frame scheduler
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sched_ff <= '0;
      sched_run_ff <= 1'b0;
    end else if (phase_ff == pif_pkg::PH_INIT1) begin
      sched_ff <= '0;
      sched_run_ff <= 1'b0;
    end else if (cfg_ff.sync_mode) begin
      if (sync_rise) begin
        sched_ff <= '0;
        sched_run_ff <= 1'b1;
      end else if (tick && sched_run_ff) begin
        sched_ff <= sched_ff + 10'h001;
        if ((cfg_ff.dual_slot && sched_ff == slot2) || (!cfg_ff.dual_slot && sched_ff == slot1)) begin
          sched_run_ff <= 1'b0;
        end
      end
    end else if (tick) begin
      sched_ff <= (sched_ff == cyc_len - 10'h001) ? 10'h000 : sched_ff + 10'h001;
    end
  end

  always_comb begin
    if (cfg_ff.sync_mode) begin
      req_first = tick & sched_run_ff & (sched_ff == slot1);
      req_any = req_first | (tick & sched_run_ff & cfg_ff.dual_slot & (sched_ff == slot2));
    end else begin
      req_first = tick & (phase_ff != pif_pkg::PH_INIT1) & (sched_ff == 10'h000);
      req_any = req_first;
    end
  end
  assign abort = sync_rise & tx_busy_ff;
  assign start_tx = req_any;
  assign tx_frame = req_first ? new_frame : frm_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // frame content
  assign nib_vec = {cfg_ff.rev21 ? pif_pkg::REV21 : pif_pkg::REV13,
                    cfg_ff.blocks32 ? pif_pkg::CNT32 : pif_pkg::CNT22,
                    cfg_ff.vendor, cfg_ff.stype, cfg_ff.sparam, cfg_ff.pdate, cfg_ff.lot_serial};
  assign nib_last = cfg_ff.blocks32 ? pif_pkg::NIB32_LAST : pif_pkg::NIB22_LAST;
  // nibbles past the stored content read as zero
  assign nibble = (nib_ff < 6'd22) ? nib_vec[7'd87 - {nib_ff, 2'b00} -: 4] : 4'h0;
  assign fifo_pop = req_first & (phase_ff == pif_pkg::PH_RUN) & fifo_valid;

  always_comb begin
    val = pif_pkg::CODE_READY;
    e0 = 1'b0;
    a_word = '0;
    unique case (phase_ff)
      pif_pkg::PH_INIT1: begin
        a_word = '0;
      end
      pif_pkg::PH_INIT2: begin
        val = is_data_ff ? (pif_pkg::NIB_BASE | {6'h00, nibble}) : (pif_pkg::ID_BASE | {6'h00, nib_ff[3:0]});
        a_word = pif_place(cfg_ff.mode16, val, 1'b0);
      end
      pif_pkg::PH_INIT3: begin
        // supply and gain flags are not looked at here
        val = defect_ff ? pif_pkg::CODE_DEFECT : pif_pkg::CODE_READY;
        a_word = pif_place(cfg_ff.mode16, val, ~defect_ff);
      end
      pif_pkg::PH_RUN: begin
        e0 = defect_ff | diag_i.ovv | diag_i.uvv | diag_i.mag;
        if (defect_ff) begin
          val = pif_pkg::CODE_DEFECT;
        end else if (diag_i.ovv) begin
          val = pif_pkg::CODE_OVV;
        end else if (diag_i.uvv) begin
          val = pif_pkg::CODE_UVV;
        end else begin
          val = pif_pkg::CODE_MAG;
        end
        if (e0) begin
          a_word = pif_place(cfg_ff.mode16, val, 1'b0);
        end else begin
          a_word = fifo_valid ? fifo_data : last_smp_ff;
        end
      end
    endcase
    new_frame = pif_build(cfg_ff.mode16, (phase_ff == pif_pkg::PH_RUN) ? fcnt_ff : 3'h0, e0, a_word);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start-up sequence
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_ff <= pif_pkg::PH_INIT1;
      ph1_cnt_ff <= '0;
      nib_ff <= '0;
      is_data_ff <= 1'b0;
      rep_ff <= '0;
      ph3_cnt_ff <= '0;
      fcnt_ff <= '0;
      frm_ff <= '0;
      last_smp_ff <= '0;
    end else begin
      if (req_first) begin
        frm_ff <= new_frame;
      end
      if (fifo_pop) begin
        last_smp_ff <= fifo_data;
      end
      unique case (phase_ff)
        pif_pkg::PH_INIT1: begin
          if (cfg_ok_ff) begin
            ph1_cnt_ff <= ph1_cnt_ff + 24'h000001;
          end
          if (ph1_cnt_ff == 24'(PH1_CYC - 1)) begin
            phase_ff <= pif_pkg::PH_INIT2;
          end else if (sync_rise && ph1_cnt_ff >= 24'(SYNC_MIN_CYC)) begin
            phase_ff <= pif_pkg::PH_INIT2;
          end
        end
        pif_pkg::PH_INIT2: begin
          if (req_first) begin
            is_data_ff <= ~is_data_ff;
            if (is_data_ff) begin
              if (nib_ff == nib_last) begin
                nib_ff <= '0;
                rep_ff <= rep_ff + 2'h1;
                if (rep_ff == cfg_ff.rep_k) begin
                  phase_ff <= pif_pkg::PH_INIT3;
                end
              end else begin
                nib_ff <= nib_ff + 6'h01;
              end
            end
          end
        end
        pif_pkg::PH_INIT3: begin
          if (req_first && ph3_cnt_ff != 4'(pif_pkg::PH3_FRAMES - 1)) begin
            ph3_cnt_ff <= ph3_cnt_ff + 4'h1;
          end else if (req_first && !defect_ff) begin
            phase_ff <= pif_pkg::PH_RUN;
          end
        end
        pif_pkg::PH_RUN: begin
          if (req_first) begin
            fcnt_ff <= fcnt_ff + 3'h1;
          end
        end
      endcase
    end
  end

  // defect is sticky; masked in phases one and two, shown from phase three
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      defect_ff <= 1'b0;
    end else if (diag_i.defect) begin
      defect_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bit shifter
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_busy_ff <= 1'b0;
      bit_left_ff <= '0;
      btick_ff <= '0;
      sh_ff <= '0;
      frm_ticks_ff <= '0;
    end else if (start_tx) begin
      tx_busy_ff <= 1'b1;
      sh_ff <= tx_frame;
      bit_left_ff <= cfg_ff.mode16 ? 5'(pif_pkg::LEN16 - 1) : 5'(pif_pkg::LEN20 - 1);
      btick_ff <= '0;
      frm_ticks_ff <= '0;
    end else if (abort) begin
      tx_busy_ff <= 1'b0;
      sh_ff <= '0;
    end else if (tx_busy_ff && tick) begin
      frm_ticks_ff <= frm_ticks_ff + 10'h001;
      if (btick_ff == bit_len - 5'h01) begin
        btick_ff <= '0;
        sh_ff <= {sh_ff[23:0], 1'b0};
        if (bit_left_ff == 5'h00) begin
          tx_busy_ff <= 1'b0;
        end else begin
          bit_left_ff <= bit_left_ff - 5'h01;
        end
      end else begin
        btick_ff <= btick_ff + 5'h01;
      end
    end
  end

  assign psi5_tx_o = sh_ff[24];
  assign tx_active_o = tx_busy_ff;
  assign phase_o = phase_ff;

  pif_fifo #(.W(pif_pkg::SMP_W), .D(pif_pkg::FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .in_valid_i(smp_valid_i),
    .in_ready_o(smp_ready_o),
    .in_data_i(smp_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  a_bit_lo_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    tx_busy_ff && !cfg_ff.high_rate |-> btick_ff < 5'd16)
    else $error("low-rate bit longer than 16 ticks");
  a_bit_hi_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    tx_busy_ff && cfg_ff.high_rate |-> btick_ff < 5'd14)
    else $error("high-rate bit longer than 14 ticks");
  a_frame_lo_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(tx_busy_ff) && !$past(abort) && !cfg_ff.mode16 && !cfg_ff.high_rate |-> $past(frm_ticks_ff) == 10'd399)
    else $error("low-rate frame not 400 ticks");
  a_frame_hi_len: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(tx_busy_ff) && !$past(abort) && cfg_ff.high_rate |->
      $past(frm_ticks_ff) == (cfg_ff.mode16 ? 10'd293 : 10'd349))
    else $error("high-rate frame length wrong");
  a_cycle_lo_wrap: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !cfg_ff.sync_mode && !cfg_ff.high_rate && tick && sched_ff == 10'd599 |=> sched_ff == 10'd0)
    else $error("low-rate repetition not 600 ticks");
  a_cycle_hi_wrap: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !cfg_ff.sync_mode && cfg_ff.high_rate && tick && sched_ff == 10'd532 |=> sched_ff == 10'd0)
    else $error("high-rate repetition not 533 ticks");
  a_ph1_quiet: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    phase_ff == pif_pkg::PH_INIT1 |-> !tx_busy_ff && !psi5_tx_o)
    else $error("frame sent during phase one");
  a_defect_stays: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    phase_ff == pif_pkg::PH_INIT3 && defect_ff |=> phase_ff == pif_pkg::PH_INIT3)
    else $error("left phase three after defect");
  a_sync_abort: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    abort && !start_tx |=> !tx_busy_ff ##1 !tx_busy_ff)
    else $error("frame not aborted by sync pulse");
endmodule

`default_nettype wire

// file: rtl/README_unused.sv
`timescale 1ns/1ps

// file: tb/pif_ecu_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pif_ecu_model (
  // clock and line
  input wire logic mclk_i,
  input wire logic psi5_tx_i,
  input wire logic tx_active_i,
  // sync pin
  output logic sync_o
);
  int bit_x100 = 100000;
  int cyc = 0;
  int t_rise = 0;
  int t_prev = 0;
  int t_sync = 0;
  int frame_len = 0;
  int n_frames = 0;
  logic [24:0] bits = '0;

  initial sync_o = 1'b0;

  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
  end

  // bit centres absorb the jitter of the fractional tick divider
  initial begin
    int k;
    int i;
    forever begin
      @(posedge tx_active_i);
      t_prev = t_rise;
      t_rise = cyc;
      bits = 'x;
      k = 0;
      i = 0;
      while (tx_active_i === 1'b1) begin
        @(negedge mclk_i);
        k++;
        if (i < 25 && k == (i * bit_x100 + bit_x100 / 2) / 100) begin
          bits[i] = psi5_tx_i;
          i++;
        end
      end
      frame_len = k - 1;
      n_frames++;
    end
  end

  task automatic send_sync();
    @(negedge mclk_i);
    t_sync = cyc;
    sync_o = 1'b1;
    repeat (20) @(negedge mclk_i);
    sync_o = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: tb/test_psi5_init_async_framer.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module test_psi5_init_async_framer;
  localparam int PH1 = 2000;
  localparam int SMIN = 500;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  pif_pkg::pif_cfg_t cfg = '0;
  pif_pkg::pif_diag_t diag = '0;
  wire logic sync;
  logic smp_valid = 1'b0;
  logic smp_ready;
  logic [pif_pkg::SMP_W-1:0] smp_data = 16'h0000;
  logic tx;
  logic active;
  logic [1:0] phase;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;

  pif_framer #(.PH1_CYC(PH1), .SYNC_MIN_CYC(SMIN)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .cfg_i(cfg),
    .diag_i(diag), .sync_i(sync), .smp_valid_i(smp_valid), .smp_ready_o(smp_ready), .smp_data_i(smp_data),
    .psi5_tx_o(tx), .tx_active_o(active), .phase_o(phase));

  pif_ecu_model ecu (.mclk_i(mclk_i), .psi5_tx_i(tx), .tx_active_i(active), .sync_o(sync));

  initial forever #4 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 110000) begin
      fail_count++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [31:0] near(input int a, input int b, input int tol);
    return 32'(a >= b - tol && a <= b + tol);
  endfunction

  // send order, index 0 is the first start bit
  function automatic logic [24:0] frame_of(input logic [9:0] code, input logic m16);
    logic [24:0] f;
    logic [2:0] crc;
    int n;
    f = '0;
    n = m16 ? 21 : 25;
    for (int i = 0; i < 10; i++) f[n - 13 + i] = code[i];
    crc = 3'h7;
    for (int i = 2; i < n; i++) crc = {crc[1:0], (i < n - 3) ? f[i] : 1'b0} ^ (crc[2] ? 3'h3 : 3'h0);
    f[n - 3] = crc[2];
    f[n - 2] = crc[1];
    f[n - 1] = crc[0];
    return f;
  endfunction

  task automatic do_reset(input pif_pkg::pif_cfg_t c);
    @(negedge mclk_i);
    nrst_i = 1'b0;
    cfg = c;
    repeat (3) @(negedge mclk_i);
    check({active, tx, phase, smp_ready}, 32'h01, "reset outputs");
    nrst_i = 1'b1;
  endtask

  task automatic wait_frames(input int n, input int limit);
    int k;
    k = 0;
    while (ecu.n_frames < n && k < limit) begin
      @(negedge mclk_i);
      k++;
    end
    check(32'(ecu.n_frames >= n), 1, "frame wait");
  endtask

  task automatic wait_rise(input int limit);
    int k;
    k = 0;
    while (active !== 1'b1 && k < limit) begin
      @(negedge mclk_i);
      k++;
    end
    check(32'(active === 1'b1), 1, "frame start wait");
  endtask

  // no drain before run mode, so the buffer must refuse the ninth word
  task automatic fill_fifo();
    int taken;
    taken = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk_i);
      if (smp_ready === 1'b1) taken++;
      smp_valid = 1'b1;
      smp_data = 16'h1000 + 16'(i);
    end
    @(negedge mclk_i);
    smp_valid = 1'b0;
    check(32'(taken), 8, "words accepted");
    check(32'(smp_ready), 0, "full buffer refuses");
  endtask

  task automatic test_low_async();
    pif_pkg::pif_cfg_t c;
    int f0;
    c = '0;
    do_reset(c);
    f0 = ecu.n_frames;
    repeat (PH1 - 20) @(negedge mclk_i);
    check(32'(phase), 0, "phase one held");
    check(32'(ecu.n_frames == f0 && active === 1'b0), 1, "silent phase one");
    repeat (40) @(negedge mclk_i);
    check(32'(phase), 1, "phase two entered");
    wait_frames(f0 + 1, 80000);
    check(32'(ecu.bits), 32'(frame_of(pif_pkg::ID_BASE, 1'b0)), "first id frame");
    check(near(ecu.frame_len, 25000, 3), 1, "low-rate frame length");
    wait_frames(f0 + 2, 40000);
    check(near(ecu.t_rise - ecu.t_prev, 37500, 3), 1, "low-rate period");
    check(32'(ecu.bits), 32'(frame_of(pif_pkg::NIB_BASE | 10'(pif_pkg::REV13), 1'b0)), "revision nibble");
  endtask

  task automatic test_high_sync();
    pif_pkg::pif_cfg_t c;
    int f0;
    c = '0;
    c.mode16 = 1'b1;
    c.high_rate = 1'b1;
    c.sync_mode = 1'b1;
    c.rev21 = 1'b1;
    do_reset(c);
    // receiver's bit centres follow the high-rate bit length
    ecu.bit_x100 = pif_pkg::BIT_HI * pif_pkg::CLK_KHZ * 100 / pif_pkg::F_HI_KHZ;
    fill_fifo();
    repeat (600) @(negedge mclk_i);
    check(32'(phase), 0, "phase one before sync");
    ecu.send_sync();
    repeat (10) @(negedge mclk_i);
    check(32'(phase), 1, "sync ends phase one");
    f0 = ecu.n_frames;
    repeat (1500) @(negedge mclk_i);
    check(32'(ecu.n_frames == f0 && active === 1'b0), 1, "no frame without sync");
    ecu.send_sync();
    wait_frames(f0 + 1, 30000);
    check(near(ecu.t_rise - ecu.t_sync, 5578, 60), 1, "slot one offset");
    check(32'(ecu.bits & 25'h01FFFFF), 32'(frame_of(pif_pkg::ID_BASE, 1'b1)), "16-bit id frame");
    check(near(ecu.frame_len, 13780, 4), 1, "high-rate frame length");
    ecu.send_sync();
    wait_rise(12000);
    repeat (2000) @(negedge mclk_i);
    ecu.send_sync();
    check(near(ecu.frame_len, 2006, 6), 1, "frame cut by sync");
    check(32'({active, tx}), 0, "line idle after abort");
    wait_rise(8000);
    check(near(ecu.t_rise - ecu.t_sync, 5578, 60), 1, "restart in slot one");
  endtask

  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    test_low_async();
    test_high_sync();
    final_report();
  end
endmodule

`default_nettype wire
